// ---- verilog/dpag_consts.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the data path
 * and address generator. Assumes inclusion by the core only.
 */
// How it works
// (RL1) 20-bit data, 32-bit program data buses
// (RL2) one instruction every two core clocks
// (RL3) six data regs, two 48-bit accumulators
// (RL4) four source operands, two destination writes
// (RL5) bus transfers run beside ALU write-back
// (RL6) ALU: arithmetic, logic, min/max, exp, divide
// (RL7) exponent one cycle, normalize two cycles
// (RL8) butterfly stores product sum and difference
// (RL9) ALU sets flags, some flags sticky
// (RL10) 20x20 multiply, optional left shift, 42 bits
// (RL11) barrel shifter direction set by mode bit
// (RL12) bus read shifter: round, limit, shift range
// (RL13) narrow regs limit, accumulators keep 48 bits
// (RL14) accumulator bus transfers and sub-field access
// (RL15) two addresses per cycle, both post-modified
// (RL16) five indirect modes, four of them post-modify
// (RL17) add/subtract step, wrap circular by modulus
// (RL18) wrap all ones gives bit-reversed stepping
// (RL19) stack pointer has no indexed/circular modes
// (RL20) pointer, step, wrap readable and writable
// (RL21) pointer, step, wrap loadable from program bus
// (RL22) reset clears every wrap register
// (RL23) reset keeps pointers, steps, data, stack
// (RL24) reset loads mode 00038, clears status
// (RL25) mode bits sampled at instruction start
// (RL26) eight paired pointer, step, wrap registers
`ifndef DPAG_CONSTS_SVH
`define DPAG_CONSTS_SVH
`define DPAG_MODE_RST   20'h00038
`define DPAG_WRAP_REV   20'hFFFFF
`define DPAG_MODE_PSEL  0
`define DPAG_MODE_SDIR  1
`define DPAG_MODE_DS    2
`define DPAG_ST_Z       0
`define DPAG_ST_N       1
`define DPAG_ST_C       2
`define DPAG_ST_V       3
`define DPAG_ST_SV      4
`define DPAG_ST_SL      5
`define DPAG_ADR_MODE   8'h00
`define DPAG_ADR_STAT   8'h04
`define DPAG_ADR_EXEC   8'h08
`define DPAG_ADR_AGEN   8'h0C
`define DPAG_ADR_SP     8'h10
`define DPAG_GRP_CTL    3'h0
`define DPAG_GRP_DREG   3'h2
`define DPAG_GRP_ACC    3'h3
`define DPAG_GRP_PTR    3'h4
`define DPAG_GRP_STEP   3'h5
`define DPAG_GRP_WRAP   3'h6
`define DPAG_INSTR_CLKS 2'h1
`define DPAG_NORM_CLKS  2'h3
`endif

// ---- verilog/dpag_pkg.sv ----
/*
 * Types of the data path and address generator.
 * Assumes dpag_consts.svh for the offsets, field positions and timing counts the logic uses.
 */
package dpag_pkg;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
    OP_XOR = 4'h4, OP_MIN = 4'h5, OP_MAX = 4'h6, OP_ADDC = 4'h7,
    OP_MUL = 4'h8, OP_DIVS = 4'h9, OP_MAC = 4'hA, OP_BFLY = 4'hB,
    OP_ASH = 4'hC, OP_LSH = 4'hD, OP_EXP = 4'hE, OP_NORM = 4'hF
  } dpag_op_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} dpag_st_t;
  typedef struct packed {
    logic [8:0] rsv;
    logic       uns;
    logic [2:0] dst2, dst, sd, sc, sb, sa;
    dpag_op_t   opc;
  } dpag_exec_t;
  typedef struct packed {
    logic [18:0] rsv;
    logic        spA;
    logic [2:0]  modeB, ptrB, modeA, ptrA;
  } dpag_agen_t;
  typedef struct packed {
    dpag_st_t         st;
    logic [1:0]       cnt;
    logic             ack;
    logic [31:0]      dat;
    logic [19:0]      mode;
    logic [3:0]       modeL;
    logic [7:0]       status;
    logic [5:0][19:0] narrow;
    logic [1:0][47:0] acc;
    logic [7:0][19:0] ptr, step, wrap;
    logic [19:0]      sp;
    dpag_exec_t       cmd;
    logic [19:0]      addrA, addrB;
    logic             addrStb;
  } dpag_state_t;
endpackage

// ---- verilog/dpag_core.sv ----
/*
 * Data path and dual address generator of a 20-bit fixed-point core:
 * register file, 48-bit ALU, multiplier, barrel and data shifters,
 * pointer/step/wrap file. Assumes a classic Wishbone master standing in
 * for the decoder and a program data bus for immediate loads.
 */
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "dpag_consts.svh"
module dpag_core #(
  parameter int DATA_W  = 20,
  parameter int NUM_PTR = 8
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // program data bus immediates
  input  wire logic [31:0] progData,
  input  wire logic        progLoad,
  input  wire logic [4:0]  progSel,
  // generated data addresses
  output logic [19:0]      addrA,
  output logic [19:0]      addrB,
  output logic             addrStrobe,
  // status
  output logic [7:0]       statusFlags
);
  if (DATA_W != 20 || NUM_PTR != 8) begin : g_chk
    $error("dpag_core supports only DATA_W=20 and NUM_PTR=8");
  end

  dpag_pkg::dpag_state_t s, n;

  function automatic logic [47:0] sx(input logic [19:0] v);
    return {{28{v[19]}}, v};
  endfunction

  // saturate a wide value to 20 bits, flag when limited
  function automatic logic [20:0] sat20(input logic [47:0] v);
    if ($signed(v) > $signed(sx(20'h7FFFF))) return {1'b1, 20'h7FFFF};
    if ($signed(v) < $signed(sx(20'h80000))) return {1'b1, 20'h80000};
    return {1'b0, v[19:0]};
  endfunction

  // reversed-order add gives reversed carry
  function automatic logic [19:0] rev20(input logic [19:0] v);
    logic [19:0] r;
    r = '0;
    for (int i = 0; i < 20; i++) r[i] = v[19-i];
    return r;
  endfunction

  // all ones up to the wrap's top bit
  function automatic logic [19:0] smear(input logic [19:0] v);
    logic [19:0] r;
    r = v;
    for (int i = 1; i < 20; i++) r = r | (r >> 1);
    return r;
  endfunction

  // redundant sign bits below the msb
  function automatic logic [5:0] expo(input logic [47:0] v);
    logic [5:0] e;
    logic       run;
    e = '0;
    run = 1'b1;
    for (int i = 46; i >= 0; i--) begin
      if (run && v[i] == v[47]) e = e + 6'h01;
      else run = 1'b0;
    end
    return e;
  endfunction

  // bus read path: shift, round on right, limit on left
  function automatic logic [19:0] dshift(input logic [47:0] v, input logic [1:0] ds);
    logic [47:0] w;
    logic [20:0] t;
    unique case (ds)
      2'h0: w = v;
      // round half up, then shift
      2'h1: w = 48'($signed(v + 48'h1) >>> 1);
      2'h2: w = v << 1;
      2'h3: w = v << 2;
    endcase
    t = sat20(w);
    return t[19:0];
  endfunction

  function automatic logic [19:0] wmerge(input logic [19:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [19:0] r;
    r = o;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    if (sel[2]) r[19:16] = d[19:16];
    return r;
  endfunction

  // post-modify of one pointer with its paired step and wrap
  function automatic logic [19:0] nextAddr(input logic [19:0] p, input logic [19:0] st,
                                           input logic [19:0] w, input logic [2:0] md);
    logic [19:0] d;
    logic [19:0] msk;
    logic [19:0] off;
    logic [20:0] nx;
    logic        up;
    d = (md == 3'h1 || md == 3'h2) ? 20'h00001 : st;                  // [RL16]
    up = (md == 3'h1 || md == 3'h3);
    // offset within the power-of-two block
    msk = smear(w - 20'h00001);
    off = p & msk;
    nx = up ? {1'b0, off} + {1'b0, d} : {1'b0, off} - {1'b0, d};
    if (up && nx >= {1'b0, w}) nx = nx - {1'b0, w};                   // [RL17]
    if (!up && nx[20]) nx = nx + {1'b0, w};                           // [RL17]
    if (md == 3'h0 || md > 3'h4) return p;                            // [RL16]
    if (w == `DPAG_WRAP_REV)
      return rev20(up ? rev20(p) + rev20(d) : rev20(p) - rev20(d));   // [RL18]
    if (w == 20'h00000) return up ? p + d : p - d;
    return (p & ~msk) | nx[19:0];                                     // [RL17]
  endfunction

  logic [3:0][47:0] op;
  logic [39:0]      p40;
  logic [41:0]      p42;
  logic [47:0]      prod;
  logic [47:0]      r1;
  // r2: butterfly's second result
  logic [47:0]      r2;
  logic [47:0]      a;
  logic [47:0]      b;
  logic [47:0]      c;
  logic [47:0]      dd;
  logic [47:0]      sh;
  logic [48:0]      sum;
  logic [20:0]      lim1;
  logic [20:0]      lim2;
  logic [5:0]       mag;
  logic             sgn;
  logic             cy;
  logic             ov;
  logic             two;
  logic             isRight;
  logic             req;
  logic             hit;
  logic [2:0]       grp;
  logic [2:0]       ri;
  logic [31:0]      rd;
  logic [19:0]      ptrMod;
  dpag_pkg::dpag_agen_t ag;

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.addrStb = 1'b0;
    // four source operands in one instruction
    for (int k = 0; k < 4; k++) begin                                  // [RL4]
      ri = (k == 0) ? s.cmd.sa : (k == 1) ? s.cmd.sb : (k == 2) ? s.cmd.sc : s.cmd.sd;
      op[k] = (ri < 3'h2) ? s.acc[ri[0]] : sx(s.narrow[3'(ri - 3'h2)]); // [RL3] [RL13]
    end
    a = op[0];
    b = op[1];
    c = op[2];
    dd = op[3];
    // multiplier on the low 20 bits of each operand
    p40 = s.cmd.uns ? 40'(a[19:0] * b[19:0])
                    : 40'($signed(a[19:0]) * $signed(b[19:0]));     // [RL10]
    sgn = ~s.cmd.uns & p40[39];
    p42 = s.modeL[`DPAG_MODE_PSEL] ? {sgn, p40, 1'b0} : {sgn, sgn, p40}; // [RL10] [RL25]
    prod = {{6{sgn}}, p42};
    // barrel shifter, amount is signed low bits of second operand
    mag = b[5] ? 6'(-b[5:0]) : b[5:0];
    isRight = b[5] ^ s.modeL[`DPAG_MODE_SDIR];                         // [RL11]
    if (s.cmd.opc == dpag_pkg::OP_ASH)
      sh = isRight ? 48'($signed(a) >>> mag) : a << mag;               // [RL11]
    else
      sh = isRight ? a >> mag : a << mag;                              // [RL11]
    sum = '0;
    r2 = '0;
    two = 1'b0;
    cy = 1'b0;
    ov = 1'b0;
    unique case (s.cmd.opc)                                            // [RL6]
      dpag_pkg::OP_ADD:  sum = {1'b0, a} + {1'b0, b};
      dpag_pkg::OP_ADDC: sum = {1'b0, a} + {1'b0, b} + {48'h0, s.status[`DPAG_ST_C]};
      dpag_pkg::OP_SUB:  sum = {1'b0, a} - {1'b0, b};
      dpag_pkg::OP_AND:  sum = {1'b0, a & b};
      dpag_pkg::OP_OR:   sum = {1'b0, a | b};
      dpag_pkg::OP_XOR:  sum = {1'b0, a ^ b};
      dpag_pkg::OP_MIN:  sum = {1'b0, ($signed(a) < $signed(b)) ? a : b};
      dpag_pkg::OP_MAX:  sum = {1'b0, ($signed(a) > $signed(b)) ? a : b};
      dpag_pkg::OP_MUL:  sum = {1'b0, prod};
      dpag_pkg::OP_MAC:  sum = {1'b0, c} + {1'b0, prod};
      // one non-restoring divide step
      dpag_pkg::OP_DIVS: begin
        sum = (a[47] == b[47]) ? {1'b0, a[46:0], 1'b0} - {1'b0, b}
                               : {1'b0, a[46:0], 1'b0} + {1'b0, b};
        sum[0] = (sum[47] == b[47]);
      end
      dpag_pkg::OP_BFLY: begin
        sum = {1'b0, c} + {1'b0, prod};                                // [RL8]
        r2 = dd - prod;                                                // [RL8]
        two = 1'b1;                                                    // [RL8]
      end
      dpag_pkg::OP_ASH, dpag_pkg::OP_LSH: sum = {1'b0, sh};
      dpag_pkg::OP_EXP:  sum = {43'h0, expo(a)};                       // [RL7]
      dpag_pkg::OP_NORM: sum = {1'b0, a << expo(a)};                   // [RL7]
    endcase
    r1 = sum[47:0];
    if (s.cmd.opc == dpag_pkg::OP_ADD || s.cmd.opc == dpag_pkg::OP_ADDC ||
        s.cmd.opc == dpag_pkg::OP_MAC || s.cmd.opc == dpag_pkg::OP_BFLY) begin
      cy = sum[48];
      ov = (a[47] == b[47]) && (r1[47] != a[47]);
    end
    if (s.cmd.opc == dpag_pkg::OP_SUB) begin
      cy = sum[48];
      ov = (a[47] != b[47]) && (r1[47] != a[47]);
    end
    // narrow destinations saturate
    lim1 = sat20(r1);
    lim2 = sat20(r2);

    // instruction execution; normalize holds for two instruction cycles
    if (s.st == dpag_pkg::ST_EXEC) begin
      n.cnt = s.cnt - 2'h1;
      if (s.cnt == 2'h0) begin
        n.st = dpag_pkg::ST_IDLE;
        n.ack = 1'b1;
        if (s.cmd.dst < 3'h2) n.acc[s.cmd.dst[0]] = r1;                // [RL13]
        else n.narrow[3'(s.cmd.dst - 3'h2)] = lim1[19:0];              // [RL13]
        if (two) begin                                                 // [RL4] [RL8]
          if (s.cmd.dst2 < 3'h2) n.acc[s.cmd.dst2[0]] = r2;
          else n.narrow[3'(s.cmd.dst2 - 3'h2)] = lim2[19:0];
        end
        n.status[`DPAG_ST_Z] = (r1 == 48'h0);                          // [RL9]
        n.status[`DPAG_ST_N] = r1[47];                                 // [RL9]
        n.status[`DPAG_ST_C] = cy;                                     // [RL9]
        n.status[`DPAG_ST_V] = ov;                                     // [RL9]
        n.status[`DPAG_ST_SV] = s.status[`DPAG_ST_SV] | ov;            // [RL9]
        n.status[`DPAG_ST_SL] = s.status[`DPAG_ST_SL] |
          (s.cmd.dst >= 3'h2 && lim1[20]) | (two && s.cmd.dst2 >= 3'h2 && lim2[20]); // [RL9] [RL13]
      end
    end

    // wishbone decode
    // held off in ack cycle and mid-instruction
    req = cyc_i & stb_i & ~s.ack & (s.st == dpag_pkg::ST_IDLE);
    grp = adr_i[7:5];
    ri = adr_i[4:2];
    rd = '0;
    hit = 1'b1;
    unique case (grp)
      `DPAG_GRP_CTL: begin
        if (adr_i == `DPAG_ADR_MODE) rd = {12'h0, s.mode};
        else if (adr_i == `DPAG_ADR_STAT) rd = {24'h0, s.status};
        else if (adr_i == `DPAG_ADR_EXEC) rd = s.cmd;
        else if (adr_i == `DPAG_ADR_SP) rd = {12'h0, s.sp};
        else if (adr_i != `DPAG_ADR_AGEN) hit = 1'b0;
      end
      `DPAG_GRP_DREG:                                                  // [RL12] [RL14]
        rd = {12'h0, dshift((ri < 3'h2) ? 48'($signed(s.acc[ri[0]]) >>> 20)
                                        : sx(s.narrow[3'(ri - 3'h2)]), s.mode[`DPAG_MODE_DS +: 2])};
      `DPAG_GRP_ACC: begin                                             // [RL14]
        if (ri[1:0] == 2'h0) rd = {12'h0, s.acc[ri[2]][19:0]};
        else if (ri[1:0] == 2'h1) rd = {12'h0, s.acc[ri[2]][39:20]};
        else if (ri[1:0] == 2'h2) rd = {24'h0, s.acc[ri[2]][47:40]};
        else hit = 1'b0;
      end
      `DPAG_GRP_PTR:  rd = {12'h0, s.ptr[ri]};                         // [RL20]
      `DPAG_GRP_STEP: rd = {12'h0, s.step[ri]};                        // [RL20]
      `DPAG_GRP_WRAP: rd = {12'h0, s.wrap[ri]};                        // [RL20]
      default: hit = 1'b0;
    endcase

    ag = dat_i;
    ptrMod = '0;
    if (req) begin
      n.dat = (we_i || !hit) ? 32'h0 : rd;
      n.ack = 1'b1;
      if (we_i) begin
        unique case (grp)
          `DPAG_GRP_CTL: begin
            if (adr_i == `DPAG_ADR_MODE) n.mode = wmerge(s.mode, dat_i, sel_i);
            if (adr_i == `DPAG_ADR_SP) n.sp = wmerge(s.sp, dat_i, sel_i);
            // clear by one; a same-cycle set wins
            if (adr_i == `DPAG_ADR_STAT && sel_i[0])                  // [RL9]
              n.status[`DPAG_ST_SL:`DPAG_ST_SV] = n.status[`DPAG_ST_SL:`DPAG_ST_SV] &
                ~(dat_i[`DPAG_ST_SL:`DPAG_ST_SV] & ~(n.status[`DPAG_ST_SL:`DPAG_ST_SV] &
                  ~s.status[`DPAG_ST_SL:`DPAG_ST_SV]));
            if (adr_i == `DPAG_ADR_EXEC && sel_i == 4'hF) begin        // [RL2]
              n.cmd = dat_i;
              // mode frozen for the whole instruction
              n.modeL = s.mode[3:0];                                   // [RL25]
              n.st = dpag_pkg::ST_EXEC;
              n.ack = 1'b0;
              n.cnt = (dpag_pkg::dpag_op_t'(dat_i[3:0]) == dpag_pkg::OP_NORM)
                      ? `DPAG_NORM_CLKS : `DPAG_INSTR_CLKS;            // [RL7]
            end
            if (adr_i == `DPAG_ADR_AGEN) begin                         // [RL15]
              n.addrA = ag.spA ? s.sp : s.ptr[ag.ptrA];
              n.addrB = s.ptr[ag.ptrB];
              n.addrStb = 1'b1;
              if (ag.spA) begin                                        // [RL19]
                if (ag.modeA == 3'h1 || ag.modeA == 3'h2)
                  n.sp = nextAddr(s.sp, 20'h0, 20'h0, ag.modeA);
              end else begin
                n.ptr[ag.ptrA] = nextAddr(s.ptr[ag.ptrA], s.step[ag.ptrA], s.wrap[ag.ptrA], ag.modeA); // [RL26]
              end
              // same pointer twice: B steps A's result
              ptrMod = (ag.ptrB == ag.ptrA && !ag.spA) ? n.ptr[ag.ptrB] : s.ptr[ag.ptrB];
              n.ptr[ag.ptrB] = nextAddr(ptrMod, s.step[ag.ptrB], s.wrap[ag.ptrB], ag.modeB); // [RL15] [RL26]
            end
          end
          `DPAG_GRP_DREG: begin                                        // [RL14]
            if (ri < 3'h2) n.acc[ri[0]] = {{8{dat_i[19]}}, dat_i[19:0], 20'h0};
            else n.narrow[3'(ri - 3'h2)] = wmerge(s.narrow[3'(ri - 3'h2)], dat_i, sel_i);
          end
          `DPAG_GRP_ACC: begin                                         // [RL14]
            if (ri[1:0] == 2'h0) n.acc[ri[2]][19:0] = wmerge(s.acc[ri[2]][19:0], dat_i, sel_i);
            if (ri[1:0] == 2'h1) n.acc[ri[2]][39:20] = wmerge(s.acc[ri[2]][39:20], dat_i, sel_i);
            if (ri[1:0] == 2'h2 && sel_i[0]) n.acc[ri[2]][47:40] = dat_i[7:0];
          end
          `DPAG_GRP_PTR:  n.ptr[ri] = wmerge(s.ptr[ri], dat_i, sel_i);   // [RL20]
          `DPAG_GRP_STEP: n.step[ri] = wmerge(s.step[ri], dat_i, sel_i); // [RL20]
          `DPAG_GRP_WRAP: n.wrap[ri] = wmerge(s.wrap[ri], dat_i, sel_i); // [RL20]
          default: ;
        endcase
      end
    end

    // immediates ride the program bus beside any data bus transfer
    if (progLoad) begin                                                // [RL21] [RL5]
      unique case (progSel[4:3])
        2'h0: n.ptr[progSel[2:0]] = progData[19:0];                    // [RL1]
        2'h1: n.step[progSel[2:0]] = progData[19:0];
        2'h2: n.wrap[progSel[2:0]] = progData[19:0];
        2'h3: n.sp = progData[19:0];
      endcase
    end
  end

  // data, pointer, step and stack keep their contents through reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s.st <= dpag_pkg::ST_IDLE;
      s.cnt <= 2'h0;
      s.ack <= 1'b0;
      s.dat <= 32'h0;
      s.mode <= `DPAG_MODE_RST;                                        // [RL24]
      s.modeL <= 4'h0;
      s.status <= 8'h00;                                               // [RL24]
      s.wrap <= '0;                                                    // [RL22]
      s.cmd <= '0;
      s.addrA <= 20'h0;
      s.addrB <= 20'h0;
      s.addrStb <= 1'b0;
    end else begin
      s <= n;                                                          // [RL23]
    end
  end

  assign ack_o = s.ack;
  assign dat_o = s.dat;
  assign addrA = s.addrA;
  assign addrB = s.addrB;
  assign addrStrobe = s.addrStb;
  assign statusFlags = s.status;
endmodule // dpag_core

// ---- sim/dpag_core_chk.sv ----
/*
 * Port-level checker of the data path core.
 * Assumes it is bound onto dpag_core and sees only its ports.
 */
`timescale 1ns/10ps
module dpag_core_chk #(
  parameter int DATA_W  = 20,
  parameter int NUM_PTR = 8
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [31:0] progData,
  input wire logic        progLoad,
  input wire logic [4:0]  progSel,
  input wire logic [19:0] addrA,
  input wire logic [19:0] addrB,
  input wire logic        addrStrobe,
  input wire logic [7:0]  statusFlags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_requested: assert property (ack_o |-> cyc_i && stb_i) else $error("ack without request");
  a_plain_answer: assert property ($rose(stb_i) && adr_i[7:2] != 6'h02 |=> ack_o)
    else $error("late register answer");
  a_exec_spacing: assert property ($rose(stb_i) && we_i && adr_i[7:2] == 6'h02
    |=> !ack_o ##1 !ack_o ##[1:3] ack_o) else $error("execute timing");
  a_strobe_agen: assert property (addrStrobe |-> ack_o && we_i && adr_i[7:2] == 6'h03)
    else $error("stray address strobe");
  a_addr_steady: assert property (!addrStrobe |-> $stable(addrA) && $stable(addrB))
    else $error("address moved");
  a_reset_clean: assert property (!$past(rst_n) |-> statusFlags == 8'h00 && !ack_o && addrA == 20'h00000)
    else $error("reset state");
  a_sticky_keep: assert property (statusFlags[5] && !(cyc_i && we_i && adr_i[7:2] == 6'h01)
    |=> statusFlags[5]) else $error("sticky lost");
  a_write_quiet: assert property (ack_o && we_i |-> dat_o == 32'h00000000) else $error("write data");
endmodule // dpag_core_chk

bind dpag_core dpag_core_chk #(.DATA_W(DATA_W), .NUM_PTR(NUM_PTR)) u_chk (.clock(clock), .rst_n(rst_n),
  .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .progData(progData), .progLoad(progLoad), .progSel(progSel), .addrA(addrA),
  .addrB(addrB), .addrStrobe(addrStrobe), .statusFlags(statusFlags));

// ---- sim/dpag_prog_model.sv ----
/*
 * Program data bus model: issues immediate loads.
 * Assumes one core clock shared with the core.
 */
`timescale 1ns/10ps
module dpag_prog_model (
  input wire logic  clock,
  output logic [31:0] progData,
  output logic        progLoad,
  output logic [4:0]  progSel
);
  logic        go = 1'b0;
  logic [4:0]  pSel = 5'h00;
  logic [19:0] pVal = 20'h00000;
  initial begin
    progData = 32'h00000000;
    progLoad = 1'b0;
    progSel  = 5'h00;
  end
  // idle bus toggles so a stale immediate is never mistaken for a load
  always @(posedge clock) begin
    progLoad <= go;
    progSel  <= pSel;
    progData <= go ? {12'h000, pVal} : ~progData;
  end
  task automatic load(input logic [4:0] s, input logic [19:0] v);
    @(posedge clock);
    go   <= 1'b1;
    pSel <= s;
    pVal <= v;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
  endtask
endmodule // dpag_prog_model

// ---- sim/dpag_core_bench.sv ----
/*
 * Self-checking bench of the data path core.
 * Assumes the core, its checker and the program bus model.
 */
`timescale 1ns/10ps
module dpag_core_bench;
  logic        clock = 1'b0, rstN = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ackO, progLoad, addrStrobe;
  logic [7:0]  adr = 8'h00, statusFlags;
  logic [31:0] wdat = 32'h00000000, rdat, datO, progData, v, lfsr = 32'h2B98A6A7;
  logic [4:0]  progSel;
  logic [19:0] addrA, addrB, a, b, p, pv[8], sv[8];
  int          failures = 0, comparisons = 0, cycles = 0;
  always #12.5 clock = ~clock;
  dpag_core u_dpag_core (.clock(clock), .rst_n(rstN), .adr_i(adr), .dat_i(wdat), .we_i(we), .sel_i(4'hF),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ackO), .dat_o(datO), .progData(progData), .progLoad(progLoad),
    .progSel(progSel), .addrA(addrA), .addrB(addrB), .addrStrobe(addrStrobe), .statusFlags(statusFlags));
  dpag_prog_model u_prog (.clock(clock), .progData(progData), .progLoad(progLoad), .progSel(progSel));
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [19:0] brev(input logic [19:0] x);
    for (int i = 0; i < 20; i++) brev[i] = x[19-i];
  endfunction
  function automatic logic [19:0] nxt(input logic [19:0] q, s, w, input int m);
    logic [19:0] d;
    d = (m == 1) ? 20'h00001 : (m == 2) ? 20'hFFFFF : (m == 3) ? s : (m == 4) ? -s : 20'h00000;
    if (w == 20'hFFFFF) return brev(brev(q) + brev(d));
    return q + d;
  endfunction
  function automatic logic [19:0] alu(input int op, input logic [19:0] x, y);
    case (op)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      3: return x | y;
      4: return x ^ y;
      5: return ($signed(x) < $signed(y)) ? x : y;
      default: return ($signed(x) > $signed(y)) ? x : y;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; adr <= ad; we <= w; wdat <= d;
    do @(posedge clock); while (ackO !== 1'b1);
    rdat = datO;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string n);
    wb(ad, 1'b0, 32'h00000000);
    chk(n, e, rdat);
  endtask
  task automatic agen(input logic [2:0] pA, mA, pB, mB, input logic sp);
    wb(8'h0C, 1'b1, {19'h00000, sp, mB, pB, mA, pA});
  endtask
  task automatic exec(input int op);
    wb(8'h08, 1'b1, {13'h0000, 3'd4, 3'd0, 3'd0, 3'd3, 3'd2, op[3:0]});
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rstN <= 1'b1;
    rd(8'h00, 32'h00038, "mode");
    rd(8'h04, 32'h00000, "status");
    for (int i = 0; i < 8; i++) rd(8'(8'hC0 + 4 * i), 32'h00000, "wrap");
    wb(8'h00, 1'b1, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      pv[i] = 20'(rnd());
      sv[i] = 20'(rnd());
      wb(8'(8'h80 + 4 * i), 1'b1, {12'h000, pv[i]});
      wb(8'(8'hA0 + 4 * i), 1'b1, {12'h000, sv[i]});
      rd(8'(8'h80 + 4 * i), {12'h000, pv[i]}, "pointer");
      rd(8'(8'hA0 + 4 * i), {12'h000, sv[i]}, "step");
    end
    rd(8'hFC, 32'h00000000, "unmapped");
    sv[1] = 20'(rnd());
    u_prog.load(5'h09, sv[1]);
    rd(8'hA4, {12'h000, sv[1]}, "loaded step");
    for (int m = 0; m < 5; m++) begin
      agen(3'd1, 3'(m), 3'd2, 3'(4 - m), 1'b0);
      chk("addrA", pv[1], addrA);
      chk("addrB", pv[2], addrB);
      pv[1] = nxt(pv[1], sv[1], 20'h00000, m);
      pv[2] = nxt(pv[2], sv[2], 20'h00000, 4 - m);
      rd(8'h84, {12'h000, pv[1]}, "modified A");
      rd(8'h88, {12'h000, pv[2]}, "modified B");
    end
    wb(8'hCC, 1'b1, 32'h00000003);
    u_prog.load(5'h03, 20'h00102);
    agen(3'd3, 3'd1, 3'd0, 3'd0, 1'b0);
    chk("circular addrA", 32'h00102, addrA);
    rd(8'h8C, 32'h00100, "circular wrap");
    wb(8'hD0, 1'b1, 32'h000FFFFF);
    wb(8'h90, 1'b1, 32'h00000000);
    wb(8'hB0, 1'b1, 32'h00000004);
    p = 20'h00000;
    repeat (4) begin
      agen(3'd4, 3'd3, 3'd0, 3'd0, 1'b0);
      chk("reversed addrA", p, addrA);
      p = nxt(p, 20'h00004, 20'hFFFFF, 3);
    end
    rd(8'h90, 32'h00001, "reversed pointer");
    a = 20'(rnd());
    wb(8'h10, 1'b1, {12'h000, a});
    agen(3'd0, 3'd3, 3'd0, 3'd0, 1'b1);
    chk("stack addrA", a, addrA);
    rd(8'h10, {12'h000, a}, "stack kept");
    agen(3'd0, 3'd1, 3'd0, 3'd0, 1'b1);
    rd(8'h10, {12'h000, a + 20'h00001}, "stack step");
    repeat (3) for (int op = 0; op < 7; op++) begin
      v = rnd();
      a = {{3{v[16]}}, v[16:0]};
      b = {{3{v[31]}}, v[31:15]};
      wb(8'h48, 1'b1, {12'h000, a});
      wb(8'h4C, 1'b1, {12'h000, b});
      exec(op);
      rd(8'h50, {12'h000, alu(op, a, b)}, "alu result");
    end
    wb(8'h48, 1'b1, 32'h0007FFFF);
    wb(8'h4C, 1'b1, 32'h00000001);
    exec(0);
    rd(8'h50, 32'h0007FFFF, "limited sum");
    chk("sticky set", 32'h1, statusFlags[5]);
    wb(8'h4C, 1'b1, 32'h00000000);
    exec(0);
    chk("sticky held", 32'h1, statusFlags[5]);
    wb(8'h04, 1'b1, 32'h00000030);
    chk("sticky cleared", 32'h0, statusFlags[5:4]);
    wb(8'h48, 1'b1, 32'h00000003);
    wb(8'h4C, 1'b1, 32'h00000005);
    wb(8'h00, 1'b1, 32'h00000001);
    exec(8);
    rd(8'h50, 32'h0000001E, "shifted product");
    wb(8'h00, 1'b1, 32'h00000004);
    rd(8'h48, 32'h00000002, "rounded read");
    wb(8'h4C, 1'b1, 32'h00000001);
    wb(8'h00, 1'b1, 32'h00000002);
    exec(13);
    rd(8'h50, 32'h00000001, "reversed shift");
    a = 20'(rnd());
    wb(8'h40, 1'b1, {12'h000, a});
    rd(8'h60, 32'h00000, "acc low");
    rd(8'h64, {12'h000, a}, "acc high");
    rd(8'h68, {24'h000000, {8{a[19]}}}, "acc guard");
    rstN <= 1'b0;
    repeat (2) @(posedge clock);
    rstN <= 1'b1;
    rd(8'h00, 32'h00038, "mode again");
    rd(8'h84, {12'h000, pv[1]}, "pointer kept");
    rd(8'hD0, 32'h00000, "wrap cleared");
    conclude();
  end
endmodule // dpag_core_bench
